// *** rtl/vis_pkg.sv ***
// Purpose: Constants for the virtual interrupt status unit.
// Assumes: Coprocessor selectors arrive decoded into opcode and register fields.
// Notes:   Three-bit request vectors are ordered abort, irq, fiq from high to low.
package vis_pkg;
   localparam logic [2:0]  CP_OPC1      = 3'h0;
   localparam logic [3:0]  CP_CRN       = 4'hc;
   localparam logic [3:0]  MVB_CRM      = 4'h0;
   localparam logic [2:0]  MVB_OPC2     = 3'h1;
   localparam logic [3:0]  PRS_CRM      = 4'h1;
   localparam logic [2:0]  PRS_OPC2     = 3'h0;
   localparam logic [3:0]  VRI_CRM      = 4'h1;
   localparam logic [2:0]  VRI_OPC2     = 3'h1;
   localparam int          ABORT_POS    = 8;
   localparam int          IRQ_POS      = 7;
   localparam int          FIQ_POS      = 6;
   localparam int          MVB_LSB      = 5;
   localparam logic [26:0] MVB_RESET    = 27'h0000000;
   localparam logic [2:0]  VRI_RESET    = 3'h0;
   localparam logic [4:0]  MVB_RSVD     = 5'h00;
   localparam logic [22:0] HIGH_RSVD    = 23'h000000;
   localparam logic [5:0]  LOW_RSVD     = 6'h00;
   localparam logic [31:0] RDATA_RESET  = 32'h00000000;
endpackage

// *** rtl/virtual_interrupt_status_unit.sv ***
// Purpose: Monitor vector base, pending request status and virtual request inject.
// Assumes: Mode, security and routing inputs are synchronous to ref_clk.
// Notes:   Each access is answered one cycle later by cp_done, with cp_undef on refusal.
`timescale 1ns/1ps
`default_nettype none
module virtual_interrupt_status_unit (
   input  wire logic        ref_clk,                      // Core clock, 250 MHz.
   input  wire logic        reset,                        // Synchronous, active high.
   input  wire logic        cp_valid,                     // Coprocessor access strobe.
   input  wire logic        cp_write,                     // 1 coprocessor_write, 0 read.
   input  wire logic [2:0]  cp_opc1,                      // First opcode field.
   input  wire logic [3:0]  cp_crn,                       // Primary register field.
   input  wire logic [3:0]  cp_crm,                       // Secondary register field.
   input  wire logic [2:0]  cp_opc2,                      // Second opcode field.
   input  wire logic [31:0] cp_wdata,                     // Write data.
   output logic      [31:0] cp_rdata,                     // Read data.
   output logic             cp_done,                      // Access answered.
   output logic             cp_undef,                     // Access refused.
   input  wire logic        secure_state,                 // 1 Secure state.
   input  wire logic        privileged,                   // 1 privileged mode.
   input  wire logic        external_abort_routing_bit,   // Abort taken in monitor.
   input  wire logic        irq_routing_bit,              // IRQ taken in monitor.
   input  wire logic        fiq_routing_bit,              // FIQ taken in monitor.
   input  wire logic        abort_mask_override,          // Abort override.
   input  wire logic        irq_mask_override,            // IRQ override.
   input  wire logic        fiq_mask_override,            // FIQ override.
   input  wire logic        status_abort_mask,            // Abort mask of status word.
   input  wire logic        status_irq_mask,              // IRQ mask of status word.
   input  wire logic        status_fiq_mask,              // FIQ mask of status word.
   input  wire logic        phys_abort,                   // Physical abort pending.
   input  wire logic        phys_irq,                     // Physical IRQ pending.
   input  wire logic        phys_fiq,                     // Physical FIQ pending.
   input  wire logic        virt_abort_taken,             // Virtual abort entry pulse.
   input  wire logic        virt_irq_taken,               // Virtual IRQ entry pulse.
   input  wire logic        virt_fiq_taken,               // Virtual FIQ entry pulse.
   input  wire logic        in_wait_state,                // Waiting for event/interrupt.
   output logic      [31:0] monitor_vector_base_out,      // Monitor vector base.
   output logic             virt_abort_req,               // Virtual abort to take.
   output logic             virt_irq_req,                 // Virtual IRQ to take.
   output logic             virt_fiq_req,                 // Virtual FIQ to take.
   output logic             wake_up                       // Wake from wait state.
);

   typedef struct packed {
      logic [26:0] mvb;
      logic [2:0]  vri;
      logic [31:0] rdata;
      logic        done;
      logic        undef;
      logic [2:0]  take;
      logic        wake;
   } state_s;

   state_s      st;
   state_s      next_st;

   logic [2:0]  route;
   logic [2:0]  ovr;
   logic [2:0]  pmask;
   logic [2:0]  phys;
   logic [2:0]  taken;
   logic [2:0]  vsel;
   logic [2:0]  vpend;
   logic [2:0]  status3;
   logic        hit_mvb;
   logic        hit_prs;
   logic        hit_vri;
   logic        access_ok;

   function automatic logic sel_match(input logic [2:0] opc1,
                                      input logic [3:0] crn,
                                      input logic [3:0] crm,
                                      input logic [2:0] opc2,
                                      input logic [3:0] want_crm,
                                      input logic [2:0] want_opc2);
      sel_match = (opc1 == vis_pkg::CP_OPC1) && (crn == vis_pkg::CP_CRN) &&
                  (crm == want_crm) && (opc2 == want_opc2);
   endfunction

   assign route = {external_abort_routing_bit, irq_routing_bit, fiq_routing_bit};
   assign ovr   = {abort_mask_override, irq_mask_override, fiq_mask_override};
   assign pmask = {status_abort_mask, status_irq_mask, status_fiq_mask};
   assign phys  = {phys_abort, phys_irq, phys_fiq};
   assign taken = {virt_abort_taken, virt_irq_taken, virt_fiq_taken};

   assign hit_mvb = sel_match(cp_opc1, cp_crn, cp_crm, cp_opc2,
                              vis_pkg::MVB_CRM, vis_pkg::MVB_OPC2);
   assign hit_prs = sel_match(cp_opc1, cp_crn, cp_crm, cp_opc2,
                              vis_pkg::PRS_CRM, vis_pkg::PRS_OPC2);
   assign hit_vri = sel_match(cp_opc1, cp_crn, cp_crm, cp_opc2,
                              vis_pkg::VRI_CRM, vis_pkg::VRI_OPC2);

   // Unprivileged, unmapped, non-secure monitor base and status writes are refused.
   assign access_ok = privileged &&
                      ((hit_mvb && secure_state) ||
                       (hit_prs && !cp_write) ||
                       hit_vri);

   // An injected request is pending only where routing and override are both set.
   assign vpend   = st.vri & route & ovr;
   assign vsel    = {3{!secure_state}} & route & ovr;
   assign status3 = (vsel & st.vri) | (~vsel & phys);

   always_comb begin
      next_st       = st;
      next_st.done  = cp_valid;
      next_st.undef = cp_valid && !access_ok;
      next_st.rdata = vis_pkg::RDATA_RESET;
      next_st.take  = vpend & {3{!secure_state}} & ~pmask;
      next_st.wake  = in_wait_state && ((vpend | phys) != 3'h0);
      if (taken[2]) begin
         next_st.vri[2] = 1'b0;
      end
      if (cp_valid && access_ok) begin
         if (cp_write) begin
            if (hit_mvb) begin
               next_st.mvb = cp_wdata[31:vis_pkg::MVB_LSB];
            end
            if (hit_vri) begin
               // A software write follows the hardware clear, so a set wins.
               next_st.vri = cp_wdata[vis_pkg::ABORT_POS:vis_pkg::FIQ_POS];
            end
         end else if (hit_mvb) begin
            next_st.rdata = {st.mvb, vis_pkg::MVB_RSVD};
         end else if (hit_prs) begin
            next_st.rdata = {vis_pkg::HIGH_RSVD, status3,
                             vis_pkg::LOW_RSVD};
         end else begin
            next_st.rdata = {vis_pkg::HIGH_RSVD, st.vri,
                             vis_pkg::LOW_RSVD};
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st.mvb   <= vis_pkg::MVB_RESET;
         st.vri   <= vis_pkg::VRI_RESET;
         st.rdata <= vis_pkg::RDATA_RESET;
         st.done  <= 1'b0;
         st.undef <= 1'b0;
         st.take  <= 3'h0;
         st.wake  <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign cp_rdata                = st.rdata;
   assign cp_done                 = st.done;
   assign cp_undef                = st.undef;
   assign monitor_vector_base_out = {st.mvb, vis_pkg::MVB_RSVD};
   assign virt_abort_req          = st.take[2];
   assign virt_irq_req            = st.take[1];
   assign virt_fiq_req            = st.take[0];
   assign wake_up                 = st.wake;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   sequence s_ok_write(logic hit);
      cp_valid && cp_write && access_ok && hit;
   endsequence

   sequence s_ok_read(logic hit);
      cp_valid && !cp_write && access_ok && hit;
   endsequence

   sequence s_vri_quiet;
      !(cp_valid && cp_write && access_ok && hit_vri);
   endsequence

   sequence s_abort_entry;
      virt_abort_taken && !(cp_valid && cp_write && access_ok && hit_vri);
   endsequence

   a_mvb_store: assert property (s_ok_write(hit_mvb) |=>
      monitor_vector_base_out == {$past(cp_wdata[31:5]), 5'h00})
      else $error("monitor vector base not stored");

   a_mvb_readback: assert property (s_ok_read(hit_mvb) |=>
      cp_done && !cp_undef && cp_rdata == monitor_vector_base_out)
      else $error("monitor vector base readback wrong");

   a_mvb_secure_only: assert property (
      cp_valid && hit_mvb && !secure_state |=> cp_done && cp_undef &&
      $stable(monitor_vector_base_out))
      else $error("non-secure monitor base access not refused");

   a_status_select: assert property (s_ok_read(hit_prs) |=>
      cp_rdata[8:6] == $past(status3) && !cp_undef)
      else $error("status view wrong");

   a_status_physical: assert property (
      (s_ok_read(hit_prs) and secure_state) |=> cp_rdata[8:6] ==
      $past({phys_abort, phys_irq, phys_fiq}))
      else $error("physical status bits wrong");

   a_status_reserved: assert property (s_ok_read(hit_prs) |=>
      cp_rdata[31:9] == 23'h000000 && cp_rdata[5:0] == 6'h00)
      else $error("status reserved bits not zero");

   a_status_readonly: assert property (
      cp_valid && hit_prs && (cp_write || !privileged) |=> cp_done && cp_undef)
      else $error("status access not refused");

   a_vri_write: assert property (s_ok_write(hit_vri) |=>
      st.vri == $past(cp_wdata[8:6]))
      else $error("inject register write lost");

   a_vri_hold: assert property (
      (st.vri[1] and s_vri_quiet) |=> st.vri[1])
      else $error("inject bit dropped without software");

   a_virt_take: assert property (
      ##1 virt_abort_req == $past(st.vri[2] && external_abort_routing_bit &&
      abort_mask_override && !secure_state && !status_abort_mask))
      else $error("virtual abort request wrong");

   a_virt_irq_fiq: assert property (
      ##1 {virt_irq_req, virt_fiq_req} == $past(st.vri[1:0] & route[1:0] &
      ovr[1:0] & {2{!secure_state}} & ~pmask[1:0]))
      else $error("virtual irq or fiq request wrong");

   a_abort_clear: assert property (
      (virt_abort_taken and s_vri_quiet) |=> !st.vri[2])
      else $error("abort inject bit not cleared");

   a_irq_kept: assert property (
      ((virt_irq_taken || virt_fiq_taken) and s_vri_quiet) |=>
      st.vri[1:0] == $past(st.vri[1:0]))
      else $error("irq or fiq inject bit changed");

   a_wake_virtual: assert property (
      in_wait_state && vpend != 3'h0 |=> wake_up)
      else $error("virtual request did not wake");

   a_mvb_kept: assert property (
      !(cp_valid && cp_write && access_ok && hit_mvb) |=> $stable(monitor_vector_base_out))
      else $error("monitor vector base changed without a write");

   a_mvb_secure_ok: assert property (
      cp_valid && privileged && secure_state && hit_mvb |=> cp_done && !cp_undef)
      else $error("secure monitor base access refused");

   a_refused_quiet: assert property (
      cp_valid && !access_ok |=> cp_undef && cp_rdata == 32'h00000000 &&
      $stable(monitor_vector_base_out))
      else $error("refused access had an effect");

   a_unpriv_refused: assert property (
      cp_valid && !privileged |=> cp_done && cp_undef)
      else $error("unprivileged access not refused");

   a_unmapped_refused: assert property (
      cp_valid && !(hit_mvb || hit_prs || hit_vri) |=> cp_done && cp_undef)
      else $error("unmapped selector not refused");

   a_status_shared: assert property (
      cp_valid && !cp_write && privileged && hit_prs |=> cp_done && !cp_undef)
      else $error("privileged status read refused");

   a_vri_shared: assert property (
      cp_valid && privileged && hit_vri |=> cp_done && !cp_undef)
      else $error("privileged inject access refused");

   a_status_virtual: assert property (
      (s_ok_read(hit_prs) and (!secure_state && (route & ovr) == 3'h7)) |=>
      cp_rdata[8:6] == $past(st.vri))
      else $error("status does not show injected requests");

   a_status_phys_view: assert property (
      (s_ok_read(hit_prs) and ((route & ovr) == 3'h0)) |=> cp_rdata[8:6] == $past(phys))
      else $error("status does not show physical requests");

   a_vri_readback: assert property (
      s_ok_read(hit_vri) |=> cp_done && !cp_undef && cp_rdata[8:6] == $past(st.vri))
      else $error("inject register readback wrong");

   a_vri_reserved: assert property (
      s_ok_read(hit_vri) |=> cp_rdata[31:9] == 23'h000000 && cp_rdata[5:0] == 6'h00)
      else $error("inject reserved bits not zero");

   a_done_follows: assert property (
      ##1 cp_done == $past(cp_valid))
      else $error("access answer not one cycle after strobe");

   a_idle_quiet: assert property (
      !cp_valid |=> !cp_undef && cp_rdata == 32'h00000000)
      else $error("answer lines busy without an access");

   a_write_no_data: assert property (
      cp_valid && cp_write |=> cp_rdata == 32'h00000000)
      else $error("write returned read data");

   a_abort_gate: assert property (
      !(external_abort_routing_bit && abort_mask_override) |=> !virt_abort_req)
      else $error("virtual abort requested without routing and override");

   a_irq_gate: assert property (
      !(irq_routing_bit && irq_mask_override) |=> !virt_irq_req)
      else $error("virtual irq requested without routing and override");

   a_fiq_gate: assert property (
      !(fiq_routing_bit && fiq_mask_override) |=> !virt_fiq_req)
      else $error("virtual fiq requested without routing and override");

   a_secure_no_take: assert property (
      secure_state |=> !virt_abort_req && !virt_irq_req && !virt_fiq_req)
      else $error("virtual request raised in secure state");

   a_masked_no_take: assert property (
      ##1 ({virt_abort_req, virt_irq_req, virt_fiq_req} & $past(pmask)) == 3'h0)
      else $error("virtual request raised while masked");

   a_abort_req_drops: assert property (
      s_abort_entry |=> ##1 !virt_abort_req)
      else $error("virtual abort request stayed after entry");

   a_abort_hold: assert property (
      ((st.vri[2] && !virt_abort_taken) and s_vri_quiet) |=> st.vri[2])
      else $error("abort inject bit dropped without software");

   a_fiq_hold: assert property (
      (st.vri[0] and s_vri_quiet) |=> st.vri[0])
      else $error("fiq inject bit dropped without software");

   a_wake_physical: assert property (
      in_wait_state && phys != 3'h0 |=> wake_up)
      else $error("physical request did not wake");

   a_wake_none: assert property (
      !in_wait_state |=> !wake_up)
      else $error("wake raised outside a wait state");

endmodule
`default_nettype wire

// *** verif/virtual_interrupt_status_unit_bench.sv ***
// Purpose: Self-checking bench for the virtual interrupt status unit.
// Assumes: Access answers arrive one cycle after the strobe; request levels lag by one cycle.
// Notes:   Vectors rout, ovr, msk, phys, taken, vreq are ordered abort, irq, fiq.
`timescale 1ns/1ps
`default_nettype none
module virtual_interrupt_status_unit_bench;
   logic        ref_clk       = 1'b0;
   logic        reset         = 1'b1;
   logic        cp_valid      = 1'b0;
   logic        cp_write      = 1'b0;
   logic [2:0]  cp_opc1       = 3'h0;
   logic [3:0]  cp_crn        = 4'hc;
   logic [3:0]  cp_crm        = 4'h0;
   logic [2:0]  cp_opc2       = 3'h0;
   logic [31:0] cp_wdata      = 32'h0;
   logic        secure_state  = 1'b1;
   logic        privileged    = 1'b1;
   logic        in_wait_state = 1'b0;
   logic [2:0]  rout          = 3'h0;
   logic [2:0]  ovr           = 3'h0;
   logic [2:0]  msk           = 3'h0;
   logic [2:0]  phys          = 3'h0;
   logic [2:0]  taken         = 3'h0;
   logic [2:0]  inject        = 3'h0;
   logic [2:0]  vreq;
   logic [31:0] cp_rdata;
   logic [31:0] mvb_out;
   logic        cp_done;
   logic        cp_undef;
   logic        wake_up;
   logic [31:0] d;
   logic [32:0] exp_q[$];
   int          errors        = 0;
   int          tests_run     = 0;
   int          cycles        = 0;

   virtual_interrupt_status_unit dut_u (
      .ref_clk(ref_clk), .reset(reset), .cp_valid(cp_valid), .cp_write(cp_write),
      .cp_opc1(cp_opc1), .cp_crn(cp_crn), .cp_crm(cp_crm), .cp_opc2(cp_opc2),
      .cp_wdata(cp_wdata), .cp_rdata(cp_rdata), .cp_done(cp_done), .cp_undef(cp_undef),
      .secure_state(secure_state), .privileged(privileged),
      .external_abort_routing_bit(rout[2]), .irq_routing_bit(rout[1]),
      .fiq_routing_bit(rout[0]), .abort_mask_override(ovr[2]),
      .irq_mask_override(ovr[1]), .fiq_mask_override(ovr[0]),
      .status_abort_mask(msk[2]), .status_irq_mask(msk[1]), .status_fiq_mask(msk[0]),
      .phys_abort(phys[2]), .phys_irq(phys[1]), .phys_fiq(phys[0]),
      .virt_abort_taken(taken[2]), .virt_irq_taken(taken[1]), .virt_fiq_taken(taken[0]),
      .in_wait_state(in_wait_state), .monitor_vector_base_out(mvb_out),
      .virt_abort_req(vreq[2]), .virt_irq_req(vreq[1]), .virt_fiq_req(vreq[0]),
      .wake_up(wake_up));

   initial begin
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic compare_access(input logic [32:0] got, input logic [32:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: access undef/data %h want %h", $time, got, exp);
      end
   endtask

   task automatic compare_level(input logic [35:0] got, input logic [35:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: req/wake/base %h want %h", $time, got, exp);
      end
   endtask

   // Each access holds the strobe for one edge and notes the expected answer.
   task automatic access(input logic wr, input logic [3:0] crn, input logic [3:0] crm,
                         input logic [2:0] opc2, input logic [31:0] wd,
                         input logic [31:0] erd, input logic eund);
      @(posedge ref_clk);
      cp_valid <= 1'b1;
      cp_write <= wr;
      cp_crn <= crn;
      cp_crm <= crm;
      cp_opc2 <= opc2;
      cp_wdata <= wd;
      exp_q.push_back({eund, erd});
      @(posedge ref_clk);
      cp_valid <= 1'b0;
   endtask

   function automatic logic [31:0] status_exp();
      logic [2:0] v;
      v = secure_state ? 3'h0 : (rout & ovr);
      return {23'h0, (v & inject) | (~v & phys), 6'h0};
   endfunction

   task automatic check_levels();
      logic [2:0] e;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      // Taken from the inputs that the last edge saw, so late level changes count.
      e = inject & rout & ovr & ~msk & {3{~secure_state}};
      compare_level({vreq, wake_up, mvb_out}, {e, in_wait_state & |(phys | (inject & rout
                    & ovr)), d & 32'hffffffe0});
   endtask

   always @(negedge ref_clk) begin
      if (cp_done === 1'b1) begin
         if (exp_q.size() == 0) begin
            errors++;
            $display("mismatch at %0t: answer without an access", $time);
         end else begin
            compare_access({cp_undef, cp_rdata}, exp_q.pop_front());
         end
      end
   end

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         $display("mismatch at %0t: timeout", $time);
         end_of_test();
      end
   end

   initial begin
      void'($urandom(82470));
      d = 32'h0;
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      access(1'b0, 4'hc, 4'h0, 3'h1, 32'h0, 32'h0, 1'b0);
      check_levels();
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         d = $urandom();
         access(1'b1, 4'hc, 4'h0, 3'h1, d, 32'h0, 1'b0);
         access(1'b0, 4'hc, 4'h0, 3'h1, 32'h0, d & 32'hffffffe0, 1'b0);
      end
      check_levels();
      secure_state <= 1'b0;
      access(1'b1, 4'hc, 4'h0, 3'h1, 32'hffffffff, 32'h0, 1'b1);
      secure_state <= 1'b1;
      privileged <= 1'b0;
      access(1'b0, 4'hc, 4'h0, 3'h1, 32'h0, 32'h0, 1'b1);
      access(1'b0, 4'hc, 4'h1, 3'h0, 32'h0, 32'h0, 1'b1);
      access(1'b1, 4'hc, 4'h1, 3'h1, 32'h1c0, 32'h0, 1'b1);
      privileged <= 1'b1;
      access(1'b0, 4'hc, 4'h0, 3'h1, 32'h0, d & 32'hffffffe0, 1'b0);
      access(1'b1, 4'hc, 4'h1, 3'h0, 32'h1c0, 32'h0, 1'b1);
      access(1'b0, 4'hd, 4'h1, 3'h0, 32'h0, 32'h0, 1'b1);
      cp_opc1 <= 3'h1;
      access(1'b0, 4'hc, 4'h1, 3'h1, 32'h0, 32'h0, 1'b1);
      cp_opc1 <= 3'h0;
      access(1'b0, 4'hc, 4'h1, 3'h1, 32'h0, 32'h0, 1'b0);
      $display("test access rights done");
      for (int i = 0; i < 40; i++) begin
         @(posedge ref_clk);
         {secure_state, rout, ovr, msk, phys, in_wait_state} <= 14'($urandom());
         @(negedge ref_clk);
         inject = 3'($urandom());
         access(1'b1, 4'hc, 4'h1, 3'h1, ~32'h1c0 | {23'h0, inject, 6'h0}, 32'h0, 1'b0);
         access(1'b0, 4'hc, 4'h1, 3'h1, 32'h0, {23'h0, inject, 6'h0}, 1'b0);
         access(1'b0, 4'hc, 4'h1, 3'h0, 32'h0, status_exp(), 1'b0);
         check_levels();
      end
      $display("test random views done");
      @(posedge ref_clk);
      {secure_state, rout, ovr, msk, phys, in_wait_state} <= {1'b0, 12'hfc0, 1'b1};
      inject = 3'h7;
      access(1'b1, 4'hc, 4'h1, 3'h1, 32'h1c0, 32'h0, 1'b0);
      check_levels();
      @(posedge ref_clk);
      taken <= 3'h7;
      @(posedge ref_clk);
      taken <= 3'h0;
      inject = 3'h3;
      access(1'b0, 4'hc, 4'h1, 3'h1, 32'h0, 32'h0c0, 1'b0);
      access(1'b0, 4'hc, 4'h1, 3'h0, 32'h0, 32'h0c0, 1'b0);
      @(posedge ref_clk);
      msk <= 3'h7;
      check_levels();
      inject = 3'h0;
      access(1'b1, 4'hc, 4'h1, 3'h1, 32'h0, 32'h0, 1'b0);
      access(1'b0, 4'hc, 4'h1, 3'h0, 32'h0, 32'h0, 1'b0);
      check_levels();
      $display("test taken and clear done");
      repeat (3) @(posedge ref_clk);
      if (exp_q.size() != 0) begin
         errors++;
         $display("mismatch at %0t: %0d answers missing", $time, exp_q.size());
      end
      end_of_test();
   end
endmodule
`default_nettype wire
